//--- rtl/gate_drive_consts.vh
// constants for the power stage gate drive logic
// Behaviour
// R1 - pwm high: low side off, then high on
// R2 - pwm low: high side off, then low on
// R3 - tri-state held through hold-off: both off
// R4 - hold-off is 150 ns; shorter ignored
// R5 - select low allows emulation, high forces ccm
// R6 - emulation with pwm low: zero crossing ends low
// R7 - emulation: low on if current positive
// R8 - select changes take effect at once
// R9 - both inputs tri-state: deep standby, gates off
// R10 - never both gate enables together
// R11 - wait for opposite gate sensed low first
// R12 - fixed built-in delay before enabling other
// R13 - lockout at start-up holds gates low
// R14 - falling supply lockout clamps gates at once
// R15 - controller sends decoded three-level codes
// R16 - resume from next pwm level after shutdown
`ifndef GATE_DRIVE_CONSTS_VH
`define GATE_DRIVE_CONSTS_VH
// ==========================================
// three-level input codes
`define LVL_LOW            2'h0
`define LVL_HIGH           2'h1
`define LVL_TRI            2'h2
// ==========================================
// timing
`define CLK_PERIOD_PS      5000
`define HOLDOFF_TIME_PS    150000
`define HOLDOFF_CYCLES     (`HOLDOFF_TIME_PS / `CLK_PERIOD_PS)
`define DEAD_DELAY_CYCLES  4
`endif

//--- rtl/tri_holdoff_timer.v
// tri-state hold-off qualifier for the pwm input
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"
module tri_holdoff_timer #(
  parameter CYCLES = `HOLDOFF_CYCLES
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       in_tri,     // pwm currently decoded as tri-state
  output reg        expired     // tri-state held for the full period
);
  reg [7:0] count;              // cycles spent in tri-state
  // ==========================================
  // counter; any non-tri cycle restarts it so short excursions are ignored
  always @(posedge core_clk) begin
    if (rst || !in_tri) begin
      count   <= 8'h00;
      expired <= 1'b0;
    end else if (count >= CYCLES[7:0] - 8'h01) begin
      expired <= 1'b1; // R4
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule // tri_holdoff_timer
`default_nettype wire

//--- rtl/dead_time_gate.v
// one gate channel: waits for opposite sensed low plus fixed delay
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"
module dead_time_gate #(
  parameter DELAY = `DEAD_DELAY_CYCLES
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       want_on,       // demanded state of this gate
  input  wire       other_req,     // opposite gate enable as driven
  input  wire       other_sensed,  // opposite gate voltage above threshold
  output wire       ready          // safe to turn this gate on
);
  reg [3:0] wait_cnt;              // cycles opposite has been fully off
  // ==========================================
  // count only while opposite is both commanded and sensed off
  always @(posedge core_clk) begin
    if (rst || other_req || other_sensed || !want_on) begin
      wait_cnt <= 4'h0; // R11
    end else if (wait_cnt != DELAY[3:0]) begin
      wait_cnt <= wait_cnt + 4'h1; // R12
    end
  end
  assign ready = (wait_cnt == DELAY[3:0]) && !other_req && !other_sensed;
endmodule // dead_time_gate
`default_nettype wire

//--- rtl/gate_drive_logic.v
// control logic of the power stage gate driver
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"
module gate_drive_logic (
  input  wire       core_clk,
  input  wire       rst,                      // supply lockout, active high
  input  wire [1:0] pwm_level,                // decoded pwm code
  input  wire [1:0] diode_emulation_select_n, // decoded select code
  input  wire       inductor_current_pos,     // inductor current above zero
  input  wire       high_sensed,              // high gate voltage above threshold
  input  wire       low_sensed,               // low gate voltage above threshold
  output reg        high_side_gate,           // high-side enable
  output reg        low_side_gate,            // low-side enable
  output reg        deep_standby_state        // deep standby indication
);
  wire pwm_tri;          // pwm in tri-state region
  wire holdoff_done;     // tri-state held long enough
  wire high_ready;       // dead time met for high side
  wire low_ready;        // dead time met for low side
  reg  want_high;        // demanded high-side state
  reg  want_low;         // demanded low-side state
  reg  next_high;
  reg  next_low;
  reg  next_standby;

  assign pwm_tri = (pwm_level == `LVL_TRI);

  tri_holdoff_timer u_holdoff (
    .core_clk (core_clk),
    .rst      (rst),
    .in_tri   (pwm_tri),
    .expired  (holdoff_done)
  );

  dead_time_gate u_high (
    .core_clk     (core_clk),
    .rst          (rst),
    .want_on      (want_high),
    .other_req    (low_side_gate),
    .other_sensed (low_sensed),
    .ready        (high_ready)
  );

  dead_time_gate u_low (
    .core_clk     (core_clk),
    .rst          (rst),
    .want_on      (want_low),
    .other_req    (high_side_gate),
    .other_sensed (high_sensed),
    .ready        (low_ready)
  );

  // ==========================================
  // demand decode; select read directly each cycle, no pwm-edge latch
  always @* begin
    want_high    = 1'b0;
    want_low     = 1'b0;
    next_standby = 1'b0;
    if (diode_emulation_select_n == `LVL_TRI) begin
      next_standby = pwm_tri; // R9
    end else begin
      case (pwm_level)
        `LVL_HIGH: want_high = 1'b1; // R1
        `LVL_LOW: begin
          if (diode_emulation_select_n == `LVL_LOW)
            want_low = inductor_current_pos; // R6 R7 R8
          else
            want_low = 1'b1; // R2 R5
        end
        // a short tri-state excursion keeps the demand of the present gates, so the
        // dead-time counters are not cleared and the gate does not glitch on return
        default: begin
          want_high = pwm_tri && !holdoff_done && high_side_gate; // R3 R4
          want_low  = pwm_tri && !holdoff_done && low_side_gate;
        end
      endcase
    end
  end

  // ==========================================
  // next gate state; turn-off immediate, turn-on only when dead time met
  always @* begin
    next_high = want_high && high_ready && !low_side_gate; // R10 R16
    next_low  = want_low && low_ready && !high_side_gate && !next_high; // R10
    // tri-state short of hold-off keeps the present gates (still safe)
    if (pwm_tri && !holdoff_done) begin
      next_high = high_side_gate && !low_side_gate;
      next_low  = low_side_gate && !high_side_gate;
    end
    if (holdoff_done || next_standby) begin
      next_high = 1'b0; // R3
      next_low  = 1'b0;
    end
  end

  // ==========================================
  // output flops; reset is the lockout clamp
  always @(posedge core_clk) begin
    if (rst) begin
      high_side_gate     <= 1'b0; // R13 R14
      low_side_gate      <= 1'b0;
      deep_standby_state <= 1'b0;
    end else begin
      high_side_gate     <= next_high;
      low_side_gate      <= next_low;
      deep_standby_state <= next_standby;
    end
  end
endmodule // gate_drive_logic
`default_nettype wire

//--- sim/gate_drive_sva.sv
// port assertions for the gate drive logic
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"
module gate_drive_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [1:0] pwm_level,
  input wire logic [1:0] diode_emulation_select_n,
  input wire logic       inductor_current_pos,
  input wire logic       low_sensed,
  input wire logic       high_side_gate,
  input wire logic       low_side_gate,
  input wire logic       deep_standby_state
);
  // ==========
  // run length of tri-state, saturating so it never wraps back below the limit
  logic [5:0] tri_cnt;
  always @(posedge core_clk) begin
    tri_cnt <= (rst || pwm_level != `LVL_TRI) ? 6'h0 : tri_cnt + {5'h0, ~&tri_cnt};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  gates_excl_a: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates on");
  lockout_off_a: assert property ($past(rst) |-> !high_side_gate && !low_side_gate)
    else $error("gate on after lockout");
  high_wait_a: assert property ($rose(high_side_gate) |-> !$past(low_sensed) && !$past(low_sensed, 4))
    else $error("high on too soon");
  pwm_high_a: assert property (pwm_level == `LVL_HIGH |=> !low_side_gate)
    else $error("low stays on");
  pwm_low_a: assert property (pwm_level == `LVL_LOW |=> !high_side_gate)
    else $error("high stays on");
  standby_a: assert property (pwm_level == `LVL_TRI && diode_emulation_select_n == `LVL_TRI |=> deep_standby_state)
    else $error("no standby");
  holdoff_a: assert property (tri_cnt > 6'h1F |-> !high_side_gate && !low_side_gate)
    else $error("gate on after hold-off");
  zero_cross_a: assert property (diode_emulation_select_n == `LVL_LOW && pwm_level == `LVL_LOW
    && !inductor_current_pos |=> !low_side_gate)
    else $error("low on with negative current");
endmodule // gate_drive_sva
`default_nettype wire

//--- sim/gate_sense_model.sv
// gate voltage sensing of the power switches
`timescale 1ns/1ps
`default_nettype none
module gate_sense_model (
  input wire logic  core_clk,
  input wire logic  high_side_gate,
  input wire logic  low_side_gate,
  output wire logic high_sensed,
  output wire logic low_sensed
);
  // ==========
  // gate voltage lags its enable by two cycles, so dead time must really wait
  logic [1:0] hs_q = 2'h0;
  logic [1:0] ls_q = 2'h0;
  always @(posedge core_clk) begin
    hs_q <= {hs_q[0], high_side_gate};
    ls_q <= {ls_q[0], low_side_gate};
  end
  assign high_sensed = hs_q[1];
  assign low_sensed  = ls_q[1];
endmodule // gate_sense_model
`default_nettype wire

//--- sim/gate_drive_logic_tb_top.sv
// testbench for the gate drive logic
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"
module gate_drive_logic_tb_top;
  // ==========
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] pwm_level = `LVL_LOW;
  logic [1:0] diode_emulation_select_n = `LVL_HIGH;
  logic inductor_current_pos = 1'b0;
  wire logic high_sensed, low_sensed, high_side_gate, low_side_gate, deep_standby_state;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  gate_drive_logic i_gate_drive_logic (.core_clk, .rst, .pwm_level, .diode_emulation_select_n,
    .inductor_current_pos, .high_sensed, .low_sensed, .high_side_gate, .low_side_gate,
    .deep_standby_state);
  gate_sense_model i_gate_sense_model (.core_clk, .high_side_gate, .low_side_gate,
    .high_sensed, .low_sensed);
  initial forever #2.5 core_clk = ~core_clk;
  // compare {high, low, standby} against the expectation
  task chk(input logic [2:0] e);
    checks++;
    if ({high_side_gate, low_side_gate, deep_standby_state} !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %h %h", $time, {high_side_gate, low_side_gate,
        deep_standby_state}, e);
    end
  endtask
  // drive one decoded code set, let n edges pass, then compare
  task step(input logic [1:0] p, s, input logic c, input int n, input logic [2:0] e);
    @(posedge core_clk);
    pwm_level <= p;
    diode_emulation_select_n <= s;
    inductor_current_pos <= c;
    repeat (n) @(posedge core_clk);
    #1;
    chk(e);
  endtask
  task report_and_stop;
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard well above the ~160 cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    step(`LVL_HIGH, `LVL_HIGH, 1'b0, 2, 3'h0);
    step(`LVL_HIGH, `LVL_HIGH, 1'b0, 12, 3'h4);
    step(`LVL_LOW, `LVL_HIGH, 1'b0, 12, 3'h2);
    step(`LVL_LOW, `LVL_LOW, 1'b0, 4, 3'h0);
    step(`LVL_LOW, `LVL_LOW, 1'b1, 6, 3'h2);
    step(`LVL_HIGH, `LVL_HIGH, 1'b0, 12, 3'h4);
    step(`LVL_TRI, `LVL_HIGH, 1'b0, 20, 3'h4);
    step(`LVL_HIGH, `LVL_HIGH, 1'b0, 2, 3'h4);
    step(`LVL_TRI, `LVL_HIGH, 1'b0, 34, 3'h0);
    step(`LVL_LOW, `LVL_HIGH, 1'b0, 12, 3'h2);
    step(`LVL_TRI, `LVL_TRI, 1'b0, 3, 3'h1);
    step(`LVL_HIGH, `LVL_LOW, 1'b0, 12, 3'h4);
    @(posedge core_clk);
    rst <= 1'b1;
    step(`LVL_HIGH, `LVL_LOW, 1'b0, 1, 3'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    step(`LVL_HIGH, `LVL_LOW, 1'b0, 12, 3'h4);
    report_and_stop;
  end
endmodule // gate_drive_logic_tb_top
bind gate_drive_logic gate_drive_sva i_gate_drive_sva (.core_clk, .rst, .pwm_level,
  .diode_emulation_select_n, .inductor_current_pos, .low_sensed, .high_side_gate,
  .low_side_gate, .deep_standby_state);
`default_nettype wire
